// ### key_derive_digest_cmds.sv
// Command interpreter for slot key refresh, revision query and digest merge.
// Assumes an external hash core that frames the message (serial bytes,
// zero padding) and an external key store that takes the written digest.
// Functional notes
// - Refresh fails unless destination enable bit set
// - Create bit picks ancestor, else destination
// - Param1 bit2 must match origin; others zero
// - Need-MAC bit demands verified 32-byte MAC
// - Limited ancestor with zero budget fails
// - Ancestor budget ignored without create/MAC bits
// - Low slots: budget full, counter wraps
// - Failed refresh leaves budget and counter alone
// - Hash source key, header, scratch into destination
// - Successful refresh returns status zero
// - Revision query: zero params, four-byte word
// - Merge fails when scratch not valid
// - Merge zone selects config, OTP or data
// - Data zone low selector sets from-slot
// - Merge result never readable by software
// - Merge sets valid; next command clears
// - Selector below 0x8000 picks data slot
// - Merge on unlocked config zone fails
// - Verify-only key uses four extra bytes
// - Verify-only hash replaces header with extras
// - Successful merge returns status zero
`timescale 1ns/1ps
`default_nettype none
module key_derive_digest_cmds #(
  parameter logic [31:0] REVISION_WORD = 32'h0000_0001 // Arbitrary value.
) (
  input  wire logic          clk, // 50 MHz clock
  input  wire logic          rst_n, // Async reset
  input  wire logic [7:0]    awaddr, // Write address
  input  wire logic          awvalid, // Write address valid
  output logic               awready, // Write address ready
  input  wire logic [31:0]   wdata, // Write data
  input  wire logic [3:0]    wstrb, // Write strobes
  input  wire logic          wvalid, // Write data valid
  output logic               wready, // Write data ready
  output logic [1:0]         bresp, // Write response
  output logic               bvalid, // Write response valid
  input  wire logic          bready, // Write response ready
  input  wire logic [7:0]    araddr, // Read address
  input  wire logic          arvalid, // Read address valid
  output logic               arready, // Read address ready
  output logic [31:0]        rdata, // Read data
  output logic [1:0]         rresp, // Read response
  output logic               rvalid, // Read data valid
  input  wire logic          rready, // Read data ready
  input  wire logic          config_locked, // Config zone locked
  input  wire logic          scratch_load, // Nonce load pulse
  input  wire logic [255:0]  scratch_load_value, // Nonce value
  input  wire logic          scratch_load_origin, // Nonce origin bit
  output logic               sha_start, // Hash start pulse
  output logic [1:0]         sha_src_zone, // Key source zone
  output logic [15:0]        sha_src_index, // Key source index
  output logic [31:0]        sha_hdr, // Header or extra bytes
  output logic               sha_with_scratch, // Append scratch value
  output logic [255:0]       sha_scratch, // Scratch value
  input  wire logic          sha_done, // Hash done pulse
  input  wire logic [255:0]  sha_digest, // Hash result
  output logic               key_wr, // Key write pulse
  output logic [3:0]         key_wr_slot, // Key write slot
  output logic [255:0]       key_wr_data // Key write value
);
  import kdd_pkg::*;

  state_e      state;
  logic [31:0] cmd_word;
  logic [5:0]  dlen;
  logic [31:0] data_word [NUM_DATA];
  logic [15:0] settings [NUM_SLOTS];
  logic [7:0]  budget [NUM_LIMITED];
  logic [7:0]  rcount [NUM_LIMITED];
  logic [7:0]  status;
  logic [31:0] result;
  logic        done;
  logic        scratch_valid_bit;
  logic        scratch_origin_bit;
  logic        scratch_from_slot_bit;
  logic [3:0]  scratch_slot_index;
  logic        valid_at_start;
  logic        aw_full;
  logic        w_full;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  function automatic logic in_block(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input int         n);
    return a[1:0] == 2'h0 && a >= base && a < base + 8'(4 * n);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CMD || a == ADDR_CTRL || a == ADDR_STATUS ||
           a == ADDR_RESULT || a == ADDR_DLEN ||
           in_block(a, ADDR_DATA, NUM_DATA) ||
           in_block(a, ADDR_SETTINGS, NUM_SLOTS) ||
           in_block(a, ADDR_COUNT, NUM_LIMITED);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // Command fields and the settings that steer them.
  logic [7:0]  opcode;
  logic [7:0]  param1;
  logic [15:0] param2;
  logic [3:0]  dst;
  logic [15:0] dset;
  logic [3:0]  anc;
  logic        busy;
  logic        do_write;
  logic        go;
  logic [255:0] mac_value;
  logic [7:0]  chk;
  logic        verify_only;
  logic [1:0]  merge_zone;
  logic [15:0] merge_index;

  assign opcode   = cmd_word[7:0];
  assign param1   = cmd_word[15:8];
  assign param2   = cmd_word[31:16];
  assign dst      = param2[3:0];
  assign dset     = settings[dst];
  assign anc      = dset[SET_PARENT_LSB +: 4];
  assign busy     = state != S_IDLE;
  assign do_write = aw_full && w_full && !bvalid;
  assign go       = do_write && aw_addr == ADDR_CTRL && w_strb[0] &&
                    w_data[0] && !busy;

  always_comb begin
    for (int i = 0; i < NUM_DATA; i++) begin
      mac_value[32*i +: 32] = data_word[i];
    end
  end

  // Source selection for the merge; the full selector still enters
  // the header below, except for a verify-only data slot.
  always_comb begin
    verify_only = 1'b0;
    merge_index = param2;
    if (param1 == ZONE_CONFIG) begin
      merge_zone = SRC_CONFIG;
    end else if (param1 == ZONE_OTP) begin
      merge_zone = SRC_OTP;
    end else if (param2 >= SEL_TRANSPORT_MIN) begin
      merge_zone = SRC_TRANSPORT;
    end else begin
      merge_zone  = SRC_DATA;
      merge_index = {12'h000, param2[3:0]};
      verify_only = settings[param2[3:0]][SET_VERIFY_ONLY];
    end
  end

  // Parse and precondition checks, evaluated one cycle after start.
  always_comb begin
    chk = ST_OK;
    case (opcode)
      OP_REFRESH: begin
        if ((param1 & REFRESH_P1_MASK) != 8'h00 ||
            param2 > SEL_DATA_MAX) begin
          chk = ST_PARSE;
        end else if (dlen != (dset[SET_NEED_MAC] ? DLEN_MAC : DLEN_NONE)) begin
          chk = ST_PARSE;
        end else if (!dset[SET_ENABLE]) begin
          chk = ST_EXEC;
        end else if (param1[ORIGIN_BIT] != scratch_origin_bit ||
                     !valid_at_start) begin
          chk = ST_EXEC;
        end else if ((dset[SET_CREATE] || dset[SET_NEED_MAC]) &&
                     anc < 4'(NUM_LIMITED) &&
                     settings[anc][SET_LIMITED_USE] &&
                     budget[anc[2:0]] == 8'h00) begin
          // Only the ancestor budget is consulted here.
          chk = ST_EXEC;
        end
      end
      OP_REVISION: begin
        if (param1 != 8'h00 || param2 != 16'h0000 || dlen != DLEN_NONE) begin
          chk = ST_PARSE;
        end
      end
      OP_MERGE: begin
        if (param1 > ZONE_DATA) begin
          chk = ST_PARSE;
        end else if (!valid_at_start) begin
          chk = ST_EXEC;
        end else if (param1 == ZONE_CONFIG && !config_locked) begin
          chk = ST_EXEC;
        end else if (param1 != ZONE_DATA && param2 > SEL_BLOCK_MAX) begin
          chk = ST_PARSE;
        end else if (verify_only && param1 == ZONE_DATA &&
                     dlen != DLEN_EXTRA) begin
          chk = ST_PARSE;
        end
      end
      default: chk = ST_PARSE;
    endcase
  end

  // Write channel: address and data are taken in either order.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_full <= 1'b1;
        awready <= 1'b0;
      end else if (!aw_full && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_full <= 1'b1;
        wready <= 1'b0;
      end else if (!w_full && !bvalid) begin
        wready <= 1'b1;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel. The scratch value has no address at all.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata   <= 32'h0000_0000;
      if (araddr == ADDR_CMD) begin
        rdata <= cmd_word;
      end else if (araddr == ADDR_CTRL || araddr == ADDR_STATUS) begin
        rdata <= {20'h00000, scratch_valid_bit, done, busy, 1'b0, status};
      end else if (araddr == ADDR_RESULT) begin
        rdata <= result;
      end else if (araddr == ADDR_DLEN) begin
        rdata <= {26'h0000000, dlen};
      end else if (in_block(araddr, ADDR_DATA, NUM_DATA)) begin
        rdata <= data_word[araddr[4:2]];
      end else if (in_block(araddr, ADDR_SETTINGS, NUM_SLOTS)) begin
        rdata <= {16'h0000, settings[araddr[5:2]]};
      end else if (in_block(araddr, ADDR_COUNT, NUM_LIMITED)) begin
        rdata <= {16'h0000, rcount[araddr[4:2]], budget[araddr[4:2]]};
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Software-written command registers; frozen while a command runs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_word <= 32'h0000_0000;
      dlen     <= DLEN_NONE;
      for (int i = 0; i < NUM_DATA; i++) begin
        data_word[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < NUM_SLOTS; i++) begin
        settings[i] <= SETTINGS_RST;
      end
    end else if (do_write && !busy) begin
      if (aw_addr == ADDR_CMD) begin
        cmd_word <= merge(cmd_word, w_data, w_strb);
      end
      if (aw_addr == ADDR_DLEN && w_strb[0]) begin
        dlen <= w_data[5:0];
      end
      if (in_block(aw_addr, ADDR_DATA, NUM_DATA)) begin
        data_word[aw_addr[4:2]] <= merge(data_word[aw_addr[4:2]], w_data,
                                         w_strb);
      end
      if (in_block(aw_addr, ADDR_SETTINGS, NUM_SLOTS)) begin
        settings[aw_addr[5:2]] <= 16'(merge({16'h0000,
          settings[aw_addr[5:2]]}, w_data, {2'b00, w_strb[1:0]}));
      end
    end
  end

  // Budget and rewrite counters. Only the count state and idle software writes touch them;
  // every failure path bypasses the count state.
  genvar g;
  generate
    for (g = 0; g < NUM_LIMITED; g++) begin : g_count
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          budget[g] <= BUDGET_RST;
          rcount[g] <= COUNT_RST;
        end else if (state == S_COUNT && dst == 4'(g)) begin
          budget[g] <= BUDGET_FULL;
          rcount[g] <= rcount[g] + 8'h01;
        end else if (do_write && !busy &&
                     aw_addr == ADDR_COUNT + 8'(4 * g)) begin
          if (w_strb[0]) begin
            budget[g] <= w_data[7:0];
          end
          if (w_strb[1]) begin
            rcount[g] <= w_data[15:8];
          end
        end
      end
    end
  endgenerate

  // Command sequencing, hash requests and scratch state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      status <= ST_OK;
      result <= 32'h0000_0000;
      done <= 1'b0;
      valid_at_start <= 1'b0;
      scratch_valid_bit <= 1'b0;
      scratch_origin_bit <= 1'b0;
      scratch_from_slot_bit <= 1'b0;
      scratch_slot_index <= 4'h0;
      sha_scratch <= '0;
      sha_start <= 1'b0;
      sha_src_zone <= SRC_CONFIG;
      sha_src_index <= 16'h0000;
      sha_hdr <= 32'h0000_0000;
      sha_with_scratch <= 1'b0;
      key_wr <= 1'b0;
      key_wr_slot <= 4'h0;
      key_wr_data <= '0;
    end else begin
      sha_start <= 1'b0;
      key_wr    <= 1'b0;
      case (state)
        S_IDLE: begin
          if (go) begin
            valid_at_start    <= scratch_valid_bit;
            scratch_valid_bit <= 1'b0;
            done              <= 1'b0;
            state             <= S_CHECK;
          end else if (scratch_load) begin
            sha_scratch        <= scratch_load_value;
            scratch_origin_bit <= scratch_load_origin;
            scratch_valid_bit  <= 1'b1;
          end
        end
        S_CHECK: begin
          sha_hdr <= {param2[15:8], param2[7:0], param1, opcode};
          if (chk != ST_OK || opcode == OP_REVISION) begin
            status <= chk;
            result <= (chk != ST_OK) ? {24'h000000, chk} :
                      REVISION_WORD;
            done   <= 1'b1;
            state  <= S_IDLE;
          end else if (opcode == OP_REFRESH) begin
            if (dset[SET_NEED_MAC]) begin
              // MAC over ancestor key and header, no scratch.
              sha_src_zone     <= SRC_DATA;
              sha_src_index    <= {12'h000, anc};
              sha_with_scratch <= 1'b0;
              sha_start        <= 1'b1;
              state            <= S_MAC;
            end else begin
              state <= S_COUNT;
            end
          end else begin
            sha_src_zone     <= merge_zone;
            sha_src_index    <= merge_index;
            sha_with_scratch <= 1'b1;
            sha_start        <= 1'b1;
            if (verify_only && param1 == ZONE_DATA) begin
              sha_hdr <= data_word[0];
            end
            state <= S_HASH;
          end
        end
        S_MAC: begin
          if (sha_done) begin
            if (sha_digest == mac_value) begin
              state <= S_COUNT;
            end else begin
              status <= ST_MISCOMPARE;
              result <= {24'h000000, ST_MISCOMPARE};
              done   <= 1'b1;
              state  <= S_IDLE;
            end
          end
        end
        S_COUNT: begin
          // Source is the ancestor for create, the destination for roll.
          sha_src_zone     <= SRC_DATA;
          sha_src_index    <= {12'h000, dset[SET_CREATE] ? anc : dst};
          sha_with_scratch <= 1'b1;
          sha_start        <= 1'b1;
          state            <= S_HASH;
        end
        S_HASH: begin
          if (sha_done) begin
            status <= ST_OK;
            result <= {24'h000000, ST_OK};
            done   <= 1'b1;
            state  <= S_IDLE;
            if (opcode == OP_REFRESH) begin
              key_wr      <= 1'b1;
              key_wr_slot <= dst;
              key_wr_data <= sha_digest;
            end else begin
              sha_scratch       <= sha_digest;
              scratch_valid_bit <= 1'b1;
              if (param1 == ZONE_DATA && param2 <= SEL_DATA_MAX) begin
                scratch_from_slot_bit <= 1'b1;
                scratch_slot_index    <= param2[3:0];
              end else begin
                scratch_from_slot_bit <= 1'b0;
              end
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### kdd_pkg.sv
// Shared constants for the key-derivation and digest command block.
// Assumes a 32-bit AXI4-Lite master and an external hash core and key store.
package kdd_pkg;
  localparam logic [7:0] OP_REFRESH  = 8'h1C;
  localparam logic [7:0] OP_REVISION = 8'h30;
  localparam logic [7:0] OP_MERGE    = 8'h15;

  localparam logic [7:0] ST_OK         = 8'h00;
  localparam logic [7:0] ST_MISCOMPARE = 8'h01;
  localparam logic [7:0] ST_PARSE      = 8'h03;
  localparam logic [7:0] ST_EXEC       = 8'h0F;

  localparam logic [7:0] ZONE_CONFIG = 8'h00;
  localparam logic [7:0] ZONE_OTP    = 8'h01;
  localparam logic [7:0] ZONE_DATA   = 8'h02;

  localparam logic [1:0] SRC_CONFIG    = 2'h0;
  localparam logic [1:0] SRC_OTP       = 2'h1;
  localparam logic [1:0] SRC_DATA      = 2'h2;
  localparam logic [1:0] SRC_TRANSPORT = 2'h3;

  localparam logic [15:0] SEL_TRANSPORT_MIN = 16'h8000;
  localparam logic [15:0] SEL_DATA_MAX      = 16'h000F;
  localparam logic [15:0] SEL_BLOCK_MAX     = 16'h0001;

  // Field positions inside a slot settings word, then the param1 mask and origin bit.
  localparam int SET_PARENT_LSB  = 0;
  localparam int SET_VERIFY_ONLY = 4;
  localparam int SET_LIMITED_USE = 5;
  localparam int SET_CREATE      = 12;
  localparam int SET_ENABLE      = 13;
  localparam int SET_NEED_MAC    = 15;
  localparam logic [7:0] REFRESH_P1_MASK = 8'hFB;
  localparam int ORIGIN_BIT = 2;

  localparam int NUM_SLOTS    = 16;
  localparam int NUM_LIMITED  = 8;
  localparam int NUM_DATA     = 8;
  localparam logic [5:0] DLEN_MAC   = 6'h20;
  localparam logic [5:0] DLEN_EXTRA = 6'h04;
  localparam logic [5:0] DLEN_NONE  = 6'h00;
  localparam logic [7:0] BUDGET_FULL = 8'hFF;

  localparam logic [15:0] SETTINGS_RST = 16'h0000;
  localparam logic [7:0]  BUDGET_RST   = 8'h00;
  localparam logic [7:0]  COUNT_RST    = 8'h00;

  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_CTRL     = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_RESULT   = 8'h0C;
  localparam logic [7:0] ADDR_DLEN     = 8'h10;
  localparam logic [7:0] ADDR_DATA     = 8'h20;
  localparam logic [7:0] ADDR_SETTINGS = 8'h40;
  localparam logic [7:0] ADDR_COUNT    = 8'h80;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_CHECK = 5'h02,
    S_MAC   = 5'h04,
    S_COUNT = 5'h08,
    S_HASH  = 5'h10
  } state_e;
endpackage

// ### kdd_chk.sv
// Checker for the command block's bus answers and hash-side pulses.
// Bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module kdd_chk (
  input wire logic         clk, // clock
  input wire logic         rst_n, // reset
  input wire logic         awvalid, // aw valid
  input wire logic         awready, // aw ready
  input wire logic         wvalid, // w valid
  input wire logic         wready, // w ready
  input wire logic         bvalid, // b valid
  input wire logic         arvalid, // ar valid
  input wire logic         arready, // ar ready
  input wire logic         rvalid, // r valid
  input wire logic         sha_start, // hash start
  input wire logic         sha_done, // hash done
  input wire logic [255:0] sha_digest, // hash result
  input wire logic         sha_with_scratch, // scratch appended
  input wire logic         key_wr, // key write
  input wire logic [255:0] key_wr_data // key value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sha_pulse_a: assert property (sha_start |=> !sha_start)
    else $error("hash start wider than one cycle");
  key_pulse_a: assert property (key_wr |=> !key_wr)
    else $error("key write wider than one cycle");
  key_after_done_a: assert property (key_wr |-> $past(sha_done))
    else $error("key write without a hash done");
  key_data_a: assert property (
    key_wr |-> key_wr_data == $past(sha_digest))
    else $error("key value differs from the digest");
  key_scratch_a: assert property (key_wr |-> sha_with_scratch)
    else $error("key hash left out the scratch value");
  key_alone_a: assert property (key_wr |-> !sha_start)
    else $error("key write beside a hash start");
  write_answer_a: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  cover property (key_wr);
  cover property (sha_start && !sha_with_scratch);
  cover property (arvalid && arready);
endmodule
bind key_derive_digest_cmds kdd_chk u_kdd_chk (.*);
`default_nettype wire

// ### hash_model.sv
// Behavioural hash core: one done pulse for each start, short or long wait.
// The digest is a plain mix of the request, enough to tell requests apart.
`timescale 1ns/1ps
`default_nettype none
module hash_model (
  input  wire logic         clk, // clock
  input  wire logic         rst_n, // reset
  input  wire logic         slow, // long latency
  input  wire logic         sha_start, // start pulse
  input  wire logic [1:0]   sha_src_zone, // key zone
  input  wire logic [15:0]  sha_src_index, // key index
  input  wire logic [31:0]  sha_hdr, // header bytes
  input  wire logic         sha_with_scratch, // scratch appended
  input  wire logic [255:0] sha_scratch, // scratch value
  output logic              sha_done, // done pulse
  output logic [255:0]      sha_digest // result
);
  logic [1:0]   zone;
  logic [15:0]  idx;
  logic [31:0]  hdr;
  logic         ws;
  logic [255:0] scr, dig;
  logic [3:0]   cnt;
  always_ff @(posedge clk) begin
    if (sha_start) begin
      zone <= sha_src_zone;
      idx  <= sha_src_index;
      hdr  <= sha_hdr;
      ws   <= sha_with_scratch;
      scr  <= sha_scratch;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 4'h0;
      sha_done <= 1'b0;
      dig      <= '0;
    end else begin
      sha_done <= (cnt == 4'h1);
      if (cnt == 4'h1) dig <= {8{hdr ^ {14'h0, zone, idx}}} ^ (ws ? scr : '0);
      if (sha_start) cnt <= slow ? 4'h9 : 4'h2;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
  // Outside the done cycle the result lines carry the inverse, so a late
  // sample can never match by luck.
  assign sha_digest = sha_done ? dig : ~dig;
endmodule
`default_nettype wire

// ### test_key_derive_digest_cmds.sv
// Self-checking bench: commands go in over AXI4-Lite, the hash core is
// modelled, and results are read back through the register map.
`timescale 1ns/1ps
`default_nettype none
module test_key_derive_digest_cmds;
  import kdd_pkg::*;
  localparam logic [31:0]  REV = 32'h0BAD_5EED; // Arbitrary value.
  localparam logic [255:0] SCR = {8{32'h5A3C_96E1}};
  logic         clk, rst_n, awvalid, wvalid, bready, arvalid, rready, slow;
  logic         config_locked, scratch_load, scratch_load_origin;
  logic         awready, wready, bvalid, arready, rvalid, sha_start;
  logic         sha_with_scratch, sha_done, key_wr;
  logic [1:0]   bresp, rresp, sha_src_zone, rsp;
  logic [3:0]   wstrb, key_wr_slot, kslot;
  logic [7:0]   awaddr, araddr, st;
  logic [15:0]  sha_src_index;
  logic [31:0]  wdata, rdata, sha_hdr, s, h;
  logic [255:0] scratch_load_value, sha_scratch, sha_digest, key_wr_data;
  logic [255:0] kdata, prev;
  logic [31:0]  mc [5];
  logic [7:0]   ms [5];
  logic [1:0]   mz [5];
  int           n_mismatch, tests_run, cyc, nkw, n;
  wire logic [50:0] seen = {u_hash_model.zone, u_hash_model.idx,
                            u_hash_model.hdr, u_hash_model.ws};
  key_derive_digest_cmds #(.REVISION_WORD(REV))
    u_key_derive_digest_cmds (.*);
  hash_model u_hash_model (.*);
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (key_wr === 1'b1) begin
      kslot <= key_wr_slot;
      kdata <= key_wr_data;
      nkw   <= nkw + 1;
    end
    if (cyc == 30000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  function automatic logic [255:0] ed(logic [1:0] z, logic [15:0] i,
                                      logic [31:0] hh, logic w);
    return {8{hh ^ {14'h0, z, i}}} ^ (w ? SCR : 256'h0);
  endfunction
  task automatic tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [255:0] g, input logic [255:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Each channel is released only at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    s = rdata;
  endtask
  task automatic run(input logic [31:0] c, input logic [7:0] dl, input bit ld);
    if (ld) begin
      @(posedge clk);
      scratch_load <= 1'b1;
      @(posedge clk);
      scratch_load <= 1'b0;
    end
    wr(ADDR_CMD, c);
    wr(ADDR_DLEN, {24'h0, dl});
    wr(ADDR_CTRL, 32'h1);
    do rd(ADDR_STATUS); while (s[10] !== 1'b1);
    st = s[7:0];
  endtask
  initial begin
    {clk, rst_n, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {config_locked, scratch_load, scratch_load_origin} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    scratch_load_value = SCR;
    mc = '{{16'h0, 8'h03, OP_MERGE}, {16'h4, ZONE_DATA, OP_MERGE},
           {16'h1, ZONE_CONFIG, OP_MERGE}, {16'h0, ZONE_OTP, OP_MERGE},
           {16'h8001, ZONE_DATA, OP_MERGE}};
    ms = '{ST_PARSE, ST_OK, ST_OK, ST_OK, ST_OK};
    mz = '{SRC_CONFIG, SRC_DATA, SRC_CONFIG, SRC_OTP, SRC_TRANSPORT};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wr(8'hA0, 32'h1);
    chk(rsp, RESP_SLVERR);
    wr(ADDR_SETTINGS + 8'd20, 32'h2000);
    wr(ADDR_SETTINGS + 8'd12, 32'h3002);
    wr(ADDR_SETTINGS + 8'd8, 32'h0020);
    wr(ADDR_SETTINGS + 8'd24, 32'hA001);
    wr(ADDR_SETTINGS + 8'd16, 32'h0010);
    wr(ADDR_COUNT + 8'd20, 32'hFF00);
    run({16'h0, 8'h0, OP_REVISION}, 8'h0, 1'b0);
    rd(ADDR_RESULT);
    chk({st, s}, {ST_OK, REV});
    run({16'h5, 8'h0, OP_REFRESH}, 8'h0, 1'b0);
    chk(st, ST_EXEC);
    run({16'h7, 8'h0, OP_REFRESH}, 8'h0, 1'b1);
    chk(st == ST_OK, 1'b0);
    run({16'h5, 8'h04, OP_REFRESH}, 8'h0, 1'b1);
    rd(ADDR_COUNT + 8'd20);
    chk({st == ST_OK, s}, {1'b0, 32'hFF00});
    h = {16'h5, 8'h0, OP_REFRESH};
    run(h, 8'h0, 1'b1);
    rd(ADDR_COUNT + 8'd20);
    chk({st, s}, {ST_OK, 32'h00FF});
    chk(seen, {SRC_DATA, 16'h5, h, 1'b1});
    prev = ed(SRC_DATA, 16'h5, h, 1'b1);
    chk({kslot, kdata[251:0]}, {4'h5, prev[251:0]});
    run({16'h3, 8'h0, OP_REFRESH}, 8'h0, 1'b1);
    rd(ADDR_COUNT + 8'd12);
    chk({st == ST_OK, s}, 33'h0);
    wr(ADDR_COUNT + 8'd8, 32'h1);
    run({16'h3, 8'h0, OP_REFRESH}, 8'h0, 1'b1);
    rd(ADDR_COUNT + 8'd12);
    chk({st, u_hash_model.idx, s}, {ST_OK, 16'h2, 32'h01FF});
    h = {16'h6, 8'h0, OP_REFRESH};
    prev = ed(SRC_DATA, 16'h1, h, 1'b0);
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 8; j++)
        wr(ADDR_DATA + 8'(4 * j), prev[32 * j +: 32] ^ 32'(k == 0));
      slow <= k[0];
      run(h, 8'h20, 1'b1);
      rd(ADDR_COUNT + 8'd24);
      chk({st, s}, k ? {ST_OK, 32'h01FF} : {ST_MISCOMPARE, 32'h0});
    end
    run({16'h4, ZONE_DATA, OP_MERGE}, 8'h0, 1'b0);
    chk(st, ST_EXEC);
    run({16'h1, ZONE_CONFIG, OP_MERGE}, 8'h0, 1'b1);
    chk(st, ST_EXEC);
    config_locked <= 1'b1;
    wr(ADDR_DATA, 32'h1122_3344);
    n = nkw;
    for (int i = 0; i < 5; i++) begin
      run(mc[i], (i == 1) ? 8'h4 : 8'h0, 1'b1);
      rd(ADDR_STATUS);
      chk({st, s[11]}, {ms[i], i != 0});
      h = (i == 1) ? 32'h1122_3344 : mc[i];
      if (i != 0) chk(seen, {mz[i], mc[i][31:16], h, 1'b1});
    end
    chk(nkw, n);
    prev = u_hash_model.dig;
    run({16'h0, ZONE_DATA, OP_MERGE}, 8'h0, 1'b0);
    chk({st, u_hash_model.scr}, {ST_OK, prev});
    run({16'h0, 8'h0, OP_REVISION}, 8'h0, 1'b0);
    rd(ADDR_STATUS);
    chk(s[11], 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
